// [uco_defines.svh]
// offsets, field positions, reset values and counts of the serial channel
`ifndef UCO_DEFINES_SVH
`define UCO_DEFINES_SVH

`define UCO_ADDR_W 12
`define UCO_CTRL0_OFF 12'h37C
`define UCO_OPT_OFF 12'h380
`define UCO_TXDATA_OFF 12'h384
`define UCO_RXDATA_OFF 12'h388
`define UCO_STATUS_OFF 12'h38C
`define UCO_DIV_OFF 12'h390
`define UCO_ADDR_OFF 12'h394

`define UCO_C0_SRC_LO 0
`define UCO_C0_SRC_HI 1
`define UCO_C0_HS_SEL 2
`define UCO_C0_TX_EMPTY 3
`define UCO_C0_HS_DIS 4
`define UCO_C0_CLK_POL 6
`define UCO_C0_BIT_ORDER 7
`define UCO_CTRL0_RST 8'h08

`define UCO_OPT_SLEEP 0
`define UCO_OPT_INVERT 1
`define UCO_OPT_POLREV 2
`define UCO_OPT_COLL 3
`define UCO_OPT_SYNC 4
`define UCO_OPT_TXEN 5
`define UCO_OPT_RXEN 6
`define UCO_OPT_LEN8 7
`define UCO_OPT_RST 8'h80

`define UCO_ST_COLL 0
`define UCO_ST_TXDONE 1
`define UCO_ST_RXFULL 2
`define UCO_ST_OVERRUN 3
`define UCO_ST_TXSPACE 4

`define UCO_DIV_RST 8'h00
`define UCO_ADDR_RST 8'h00
`define UCO_SRC_DIV1 2'h0
`define UCO_SRC_DIV8 2'h1
`define UCO_SRC_DIV32 2'h2
`define UCO_DIV8_LAST 3'h7
`define UCO_DIV32_LAST 5'h1F
`define UCO_UART_LAST 4'hF
`define UCO_UART_MID 4'h7
`define UCO_SYNC_LAST 4'h1
`define UCO_SYNC_MID 4'h0

`endif

// [uco_pkg.sv]
// types of the serial channel
package uco_pkg;
  typedef enum logic [1:0] {
    TX_IDLE, TX_START, TX_DATA, TX_STOP
  } uco_tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } uco_rx_state_type;
endpackage

// [uco_pair_buffer.sv]
// small valid/ready buffer between register writes and the transmitter
`timescale 1ns/10ps
`default_nettype none
module uco_pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != CNT_FULL);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [uco_channel.sv]
// serial channel with option functions and control register 0 over apb
`timescale 1ns/10ps
`default_nettype none
`include "uco_defines.svh"
module uco_channel
  import uco_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`UCO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe,
  output logic sclk_o,
  input wire logic hs_i,
  output logic hs_o,
  output logic hs_oe,
  input wire logic port_data_i,
  input wire logic port_dir_i,
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic collision_irq_o
);
  // ==========================================================
  // registers and declarations
  logic [1:0] src_sel_reg;
  logic hs_sel_reg, hs_dis_reg, clk_pol_reg, bit_order_reg;
  logic [7:0] opt_reg, div_reg, addr_reg;
  logic tx_empty_reg, tx_done_reg, coll_reg, rx_full_reg, overrun_reg;
  logic [7:0] rx_data_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic [1:0] rxd_sync_reg, hs_sync_reg;
  logic [4:0] pre_reg;
  logic [7:0] div_cnt_reg;
  logic tick_reg;
  uco_tx_state_type tx_state_reg;
  uco_rx_state_type rx_state_reg;
  logic [3:0] ph_reg, rph_reg;
  logic [2:0] bit_reg, rbit_reg;
  logic [7:0] tx_sh_reg, rx_sh_reg;
  logic txd_level_reg, txd_oe_reg, sclk_reg, rts_reg, hs_o_reg, hs_oe_reg;

  logic sync_mode, msb_first, rxd_l, cts_ok, tx_load, shift_ev, sample_ev;
  logic [3:0] ph_last, ph_mid;
  logic [2:0] nbits_last;
  logic access, complete, wr_done, rd_done, mapped, tx_wr;
  logic buf_in_ready, buf_out_valid;
  logic [7:0] buf_out_data, tx_word, rx_word;
  logic rx_store, rx_accept, coll_hit;
  logic [31:0] rd_mux;
  localparam logic [7:0] CTRL0_RST = `UCO_CTRL0_RST;

  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_sync_reg <= 2'h3;
      hs_sync_reg <= 2'h3;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], rxd_i};
      hs_sync_reg <= {hs_sync_reg[0], hs_i};
    end
  end

  assign sync_mode = opt_reg[`UCO_OPT_SYNC];
  assign rxd_l = rxd_sync_reg[1] ^ opt_reg[`UCO_OPT_POLREV];
  assign msb_first = bit_order_reg & (sync_mode | opt_reg[`UCO_OPT_LEN8]);
  assign nbits_last = (sync_mode | opt_reg[`UCO_OPT_LEN8]) ? 3'h7 : 3'h6;
  assign ph_last = sync_mode ? `UCO_SYNC_LAST : `UCO_UART_LAST;
  assign ph_mid = sync_mode ? `UCO_SYNC_MID : `UCO_UART_MID;
  // low clear-to-send is needed only while the function is in use
  assign cts_ok = hs_dis_reg | hs_sel_reg | ~hs_sync_reg[1];

  // ==========================================================
  // baud generator: source prescaler then programmable divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_reg <= '0;
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      logic src_tick;
      src_tick = 1'b0;
      pre_reg <= pre_reg + 1'b1;
      case (src_sel_reg)
        `UCO_SRC_DIV1: src_tick = 1'b1;
        `UCO_SRC_DIV8: src_tick = (pre_reg[2:0] == `UCO_DIV8_LAST);
        `UCO_SRC_DIV32: src_tick = (pre_reg == `UCO_DIV32_LAST);
        default: src_tick = 1'b0;
      endcase
      tick_reg <= 1'b0;
      if (src_tick) begin
        if (div_cnt_reg >= div_reg) begin
          div_cnt_reg <= '0;
          tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // transmitter
  assign tx_load = (tx_state_reg == TX_IDLE) & opt_reg[`UCO_OPT_TXEN] &
                   buf_out_valid & cts_ok & tick_reg;
  assign tx_word = msb_first ? bit_rev(buf_out_data) : buf_out_data;
  assign shift_ev = tick_reg & (tx_state_reg != TX_IDLE) & (ph_reg == ph_last);
  assign sample_ev = tick_reg & (tx_state_reg != TX_IDLE) & (ph_reg == ph_mid);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state_reg <= TX_IDLE;
      ph_reg <= '0;
      bit_reg <= '0;
      tx_sh_reg <= '0;
      txd_level_reg <= 1'b1;
      tx_empty_reg <= 1'b1;
    end else begin
      if (tick_reg & (tx_state_reg != TX_IDLE)) begin
        ph_reg <= (ph_reg == ph_last) ? 4'h0 : ph_reg + 1'b1;
      end
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_load) begin
            ph_reg <= '0;
            bit_reg <= '0;
            tx_empty_reg <= 1'b0;
            if (sync_mode) begin
              txd_level_reg <= tx_word[0];
              tx_sh_reg <= {1'b0, tx_word[7:1]};
              tx_state_reg <= TX_DATA;
            end else begin
              txd_level_reg <= 1'b0;
              tx_sh_reg <= tx_word;
              tx_state_reg <= TX_START;
            end
          end
        end
        TX_START: begin
          if (shift_ev) begin
            txd_level_reg <= tx_sh_reg[0];
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (shift_ev) begin
            if (bit_reg == nbits_last) begin
              txd_level_reg <= 1'b1;
              if (sync_mode) begin
                tx_state_reg <= TX_IDLE;
                tx_empty_reg <= 1'b1;
              end else begin
                tx_state_reg <= TX_STOP;
              end
            end else begin
              txd_level_reg <= tx_sh_reg[0];
              tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
              bit_reg <= bit_reg + 1'b1;
            end
          end
        end
        TX_STOP: begin
          if (shift_ev) begin
            tx_state_reg <= TX_IDLE;
            tx_empty_reg <= 1'b1;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receiver: uart state machine, sync bits ride on the tx clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state_reg <= RX_IDLE;
      rph_reg <= '0;
      rbit_reg <= '0;
      rx_sh_reg <= '0;
    end else begin
      if (sync_mode) begin
        rx_state_reg <= RX_IDLE;
        if (sample_ev & (tx_state_reg == TX_DATA)) begin
          rx_sh_reg <= {rxd_l, rx_sh_reg[7:1]};
        end
      end else if (~opt_reg[`UCO_OPT_RXEN]) begin
        rx_state_reg <= RX_IDLE;
      end else if (tick_reg) begin
        rph_reg <= rph_reg + 1'b1;
        case (rx_state_reg)
          RX_IDLE: begin
            rph_reg <= '0;
            if (~rxd_l) begin
              rx_state_reg <= RX_START;
            end
          end
          RX_START: begin
            if (rph_reg == `UCO_UART_MID) begin
              rph_reg <= '0;
              rbit_reg <= '0;
              rx_state_reg <= rxd_l ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rph_reg == `UCO_UART_LAST) begin
              rx_sh_reg <= {rxd_l, rx_sh_reg[7:1]};
              rbit_reg <= rbit_reg + 1'b1;
              if (rbit_reg == nbits_last) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rph_reg == `UCO_UART_LAST) begin
              rx_state_reg <= RX_IDLE;
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  assign rx_store = opt_reg[`UCO_OPT_RXEN] & (sync_mode ?
    (sample_ev & (tx_state_reg == TX_DATA) & (bit_reg == 3'h7)) :
    (tick_reg & (rx_state_reg == RX_STOP) & (rph_reg == `UCO_UART_LAST)));
  always_comb begin
    logic [7:0] raw;
    raw = sync_mode ? {rxd_l, rx_sh_reg[7:1]} :
          (opt_reg[`UCO_OPT_LEN8] ? rx_sh_reg : {1'b0, rx_sh_reg[7:1]});
    rx_word = msb_first ? bit_rev(raw) : raw;
  end
  assign rx_accept = rx_store & ~(opt_reg[`UCO_OPT_SLEEP] & ~sync_mode &
                     (rx_word != addr_reg));
  assign coll_hit = sample_ev & opt_reg[`UCO_OPT_COLL] &
    ((txd_level_reg ^ opt_reg[`UCO_OPT_POLREV]) != rxd_sync_reg[1]);

  // ==========================================================
  // apb slave
  assign access = psel & penable;
  assign complete = access & pready_reg;
  assign wr_done = complete & pwrite & ~pslverr_reg;
  assign rd_done = complete & ~pwrite & ~pslverr_reg;
  assign tx_wr = access & pwrite & (paddr == `UCO_TXDATA_OFF);
  assign mapped = (paddr == `UCO_CTRL0_OFF) | (paddr == `UCO_OPT_OFF) |
                  (paddr == `UCO_TXDATA_OFF) | (paddr == `UCO_RXDATA_OFF) |
                  (paddr == `UCO_STATUS_OFF) | (paddr == `UCO_DIV_OFF) |
                  (paddr == `UCO_ADDR_OFF);

  always_comb begin
    rd_mux = '0;
    case (paddr)
      `UCO_CTRL0_OFF: rd_mux[7:0] = {bit_order_reg, clk_pol_reg, 1'b0,
        hs_dis_reg, tx_empty_reg, hs_sel_reg, src_sel_reg};
      `UCO_OPT_OFF: rd_mux[7:0] = opt_reg;
      `UCO_RXDATA_OFF: rd_mux[7:0] =
        rx_data_reg ^ {8{opt_reg[`UCO_OPT_INVERT]}};
      `UCO_STATUS_OFF: rd_mux[4:0] = {buf_in_ready, overrun_reg,
        rx_full_reg, tx_done_reg, coll_reg};
      `UCO_DIV_OFF: rd_mux[7:0] = div_reg;
      `UCO_ADDR_OFF: rd_mux[7:0] = addr_reg;
      default: rd_mux = '0;
    endcase
  end

  // a transmit write waits in the access phase while the buffer is full
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (complete) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (access & (~tx_wr | buf_in_ready)) begin
      pready_reg <= 1'b1;
      pslverr_reg <= ~mapped;
      prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_sel_reg <= CTRL0_RST[`UCO_C0_SRC_HI:`UCO_C0_SRC_LO];
      hs_sel_reg <= CTRL0_RST[`UCO_C0_HS_SEL];
      hs_dis_reg <= CTRL0_RST[`UCO_C0_HS_DIS];
      clk_pol_reg <= CTRL0_RST[`UCO_C0_CLK_POL];
      bit_order_reg <= CTRL0_RST[`UCO_C0_BIT_ORDER];
      opt_reg <= `UCO_OPT_RST;
      div_reg <= `UCO_DIV_RST;
      addr_reg <= `UCO_ADDR_RST;
    end else if (wr_done) begin
      case (paddr)
        `UCO_CTRL0_OFF: begin
          src_sel_reg <= pwdata[`UCO_C0_SRC_HI:`UCO_C0_SRC_LO];
          hs_sel_reg <= pwdata[`UCO_C0_HS_SEL];
          hs_dis_reg <= pwdata[`UCO_C0_HS_DIS];
          clk_pol_reg <= pwdata[`UCO_C0_CLK_POL];
          bit_order_reg <= pwdata[`UCO_C0_BIT_ORDER];
        end
        `UCO_OPT_OFF: opt_reg <= pwdata[7:0];
        `UCO_DIV_OFF: div_reg <= pwdata[7:0];
        `UCO_ADDR_OFF: addr_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sticky flags: a hardware set beats a software clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coll_reg <= 1'b0;
      tx_done_reg <= 1'b0;
      overrun_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      rx_data_reg <= '0;
    end else begin
      logic st_wr;
      st_wr = wr_done & (paddr == `UCO_STATUS_OFF);
      if (coll_hit) begin
        coll_reg <= 1'b1;
      end else if (st_wr & pwdata[`UCO_ST_COLL]) begin
        coll_reg <= 1'b0;
      end
      if (tx_state_reg != TX_IDLE && tx_empty_reg == 1'b0 &&
          ((tx_state_reg == TX_STOP) || sync_mode) &&
          shift_ev && (tx_state_reg == TX_STOP || bit_reg == nbits_last)) begin
        tx_done_reg <= 1'b1;
      end else if (st_wr & pwdata[`UCO_ST_TXDONE]) begin
        tx_done_reg <= 1'b0;
      end
      if (rx_accept & rx_full_reg &
          ~(rd_done & (paddr == `UCO_RXDATA_OFF))) begin
        overrun_reg <= 1'b1;
      end else if (st_wr & pwdata[`UCO_ST_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
      if (rx_accept) begin
        rx_data_reg <= rx_word;
        rx_full_reg <= 1'b1;
      end else if (rd_done & (paddr == `UCO_RXDATA_OFF)) begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pins: transmit line, transfer clock and shared handshake pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_oe_reg <= 1'b0;
      sclk_reg <= 1'b1;
      rts_reg <= 1'b1;
      hs_o_reg <= 1'b0;
      hs_oe_reg <= 1'b0;
    end else begin
      // open drain: enable only while the pin must be pulled low
      txd_oe_reg <= ~(txd_level_reg ^ opt_reg[`UCO_OPT_POLREV]);
      if (sync_mode & (tx_state_reg != TX_IDLE)) begin
        sclk_reg <= ph_reg[0] ^ clk_pol_reg;
      end else begin
        sclk_reg <= ~(sync_mode & clk_pol_reg);
      end
      rts_reg <= ~opt_reg[`UCO_OPT_RXEN] | rx_full_reg |
        (sync_mode ? (tx_state_reg != TX_IDLE) :
         (rx_state_reg != RX_IDLE));
      if (~hs_dis_reg & hs_sel_reg) begin
        hs_o_reg <= rts_reg;
        hs_oe_reg <= 1'b1;
      end else begin
        hs_o_reg <= port_data_i;
        hs_oe_reg <= port_dir_i;
      end
    end
  end

  uco_pair_buffer #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) tx_buffer (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(tx_wr & pready_reg),
    .in_ready(buf_in_ready),
    .in_data(pwdata[7:0] ^ {8{opt_reg[`UCO_OPT_INVERT]}}),
    .out_valid(buf_out_valid),
    .out_ready(tx_load),
    .out_data(buf_out_data)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd_o = 1'b0;
  assign txd_oe = txd_oe_reg;
  assign sclk_o = sclk_reg;
  assign hs_o = hs_o_reg;
  assign hs_oe = hs_oe_reg;
  assign tx_irq_o = tx_done_reg;
  assign rx_irq_o = rx_full_reg;
  assign collision_irq_o = coll_reg;
endmodule
`default_nettype wire

// [uco_end_marker_unused.sv]
// intentionally minimal: holds no module
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [uco_channel_props.sv]
// port assertions for the serial channel
`timescale 1ns/10ps
`default_nettype none
`include "uco_defines.svh"
module uco_channel_props #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`UCO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hs_o,
  input wire logic hs_oe,
  input wire logic port_data_i,
  input wire logic port_dir_i,
  input wire logic tx_irq_o,
  input wire logic collision_irq_o
);
  // ==========
  // helpers
  logic [7:0] ctl_m;
  logic [1:0] ctl_age;
  wire logic acc = psel && penable && pready;
  wire logic wr_st = acc && pwrite && paddr == `UCO_STATUS_OFF;
  wire logic mapped = paddr inside {`UCO_CTRL0_OFF, `UCO_OPT_OFF,
    `UCO_TXDATA_OFF, `UCO_RXDATA_OFF, `UCO_STATUS_OFF, `UCO_DIV_OFF,
    `UCO_ADDR_OFF};
  // mirror of control 0, aged so the pin logic has settled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_m <= `UCO_CTRL0_RST;
      ctl_age <= 2'h0;
    end else if (acc && pwrite && paddr == `UCO_CTRL0_OFF) begin
      ctl_m <= pwdata[7:0];
      ctl_age <= 2'h0;
    end else if (ctl_age != 2'h3) begin
      ctl_age <= ctl_age + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // assertions
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  a_ready_time: assert property (psel && penable && !pready &&
    !(pwrite && paddr == `UCO_TXDATA_OFF) |=> pready)
    else $error("pready late");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_bit5_zero: assert property (
    pready && !pwrite && paddr == `UCO_CTRL0_OFF |-> prdata[31:5] ==
    {24'h0, prdata[7:6], 1'b0}) else $error("control 0 bit 5 set");
  a_port_pass: assert property (ctl_age == 2'h3 &&
    !(ctl_m[2] && !ctl_m[4]) && $stable(port_data_i) &&
    $stable(port_dir_i) |-> hs_o == port_data_i && hs_oe == port_dir_i)
    else $error("shared pin not port");
  a_rts_drive: assert property (
    ctl_age == 2'h3 && ctl_m[2] && !ctl_m[4] |-> hs_oe)
    else $error("handshake output not driven");
  a_txirq_hold: assert property (
    tx_irq_o && !(wr_st && pwdata[1]) |=> tx_irq_o)
    else $error("transmit request lost");
  a_coll_hold: assert property (
    collision_irq_o && !(wr_st && pwdata[0]) |=> collision_irq_o)
    else $error("collision request lost");
  c_status_wr: cover property (wr_st);
  c_tx_done: cover property ($rose(tx_irq_o));
  c_collision: cover property ($rose(collision_irq_o));
  c_bad_addr: cover property (pslverr);
endmodule
bind uco_channel uco_channel_props #(.BUF_DEPTH(BUF_DEPTH)) u_props (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .hs_o(hs_o), .hs_oe(hs_oe),
  .port_data_i(port_data_i), .port_dir_i(port_dir_i),
  .tx_irq_o(tx_irq_o), .collision_irq_o(collision_irq_o)
);
`default_nettype wire

// [uco_far_end.sv]
// far-end serial device: frame receiver and sender
`timescale 1ns/10ps
`default_nettype none
module uco_far_end (
  input wire logic clk,
  input wire logic line_i,
  input wire logic sclk,
  output logic rxd,
  output logic cts_n
);
  logic en = 1'b0;
  logic inv = 1'b0;
  logic jam = 1'b0;
  logic snd = 1'b1;
  logic syn = 1'b0;
  logic pol = 1'b0;
  int sbits = 0;
  int bit_cyc = 16;
  int rx_count = 0;
  logic [7:0] rx_byte = 8'h00;
  wire logic l = line_i ^ inv;
  initial cts_n = 1'b0;
  // jam pulls the line low to provoke a collision
  assign rxd = snd & !jam;
  // ==========
  // receiver: 8 mid-bit samples, lsb first
  always begin
    @(posedge clk iff (en && !syn && l));
    @(posedge clk iff (en && !syn && !l));
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      rx_byte[i] = l;
    end
    rx_count++;
  end
  // sync mode: shift the line in on the sampling edge of the transfer clock
  always @(sclk) begin
    if (en && syn && (sclk ^ pol)) begin
      rx_byte = {l, rx_byte[7:1]};
      sbits++;
      if (sbits == 8) begin
        sbits = 0;
        rx_count++;
      end
    end
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      snd <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// [uco_channel_test.sv]
// self-checking bench for the serial channel
`timescale 1ns/10ps
`default_nettype none
`include "uco_defines.svh"
module uco_channel_test import uco_pkg::*;;
  logic clk, sys_rst, psel, penable, pwrite, port_data_i, port_dir_i;
  logic [`UCO_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, txd_o, txd_oe, sclk_o, hs_o, hs_oe, e;
  logic tx_irq_o, rx_irq_o, collision_irq_o, rxd, cts_n;
  int err_total = 0;
  int compares = 0;
  uco_channel #(.BUF_DEPTH(2)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_i(rxd), .txd_o(txd_o),
    .txd_oe(txd_oe), .sclk_o(sclk_o), .hs_i(cts_n), .hs_o(hs_o),
    .hs_oe(hs_oe), .port_data_i(port_data_i), .port_dir_i(port_dir_i),
    .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
    .collision_irq_o(collision_irq_o)
  );
  // open-drain line with pull-up
  uco_far_end far (.clk(clk), .line_i(~txd_oe), .sclk(sclk_o), .rxd(rxd),
    .cts_n(cts_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========
  // tasks
  task automatic summarize;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic got, input logic exp);
    cmp({7'h0, got}, {7'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // a full buffer may stall a data write for a whole frame
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    cmp(q[7:0], x);
  endtask
  task automatic rxw(input int c);
    for (int n = 0; n < 7000 && far.rx_count == c; n++) @(posedge clk);
  endtask
  task automatic done(input logic [7:0] c0);
    for (int n = 0; n < 2000 && tx_irq_o !== 1'b1; n++) @(posedge clk);
    rd(`UCO_CTRL0_OFF, c0 | 8'h08);
    flag(tx_irq_o, 1'b1);
    wr(`UCO_STATUS_OFF, 8'h02);
    flag(tx_irq_o, 1'b0);
  endtask
  task automatic frame(input logic [7:0] c0, input logic [7:0] op,
    input logic v, input int bc, input logic [7:0] x);
    int c;
    far.en = 1'b0;
    wr(`UCO_CTRL0_OFF, c0);
    wr(`UCO_OPT_OFF, op);
    far.inv = v;
    far.bit_cyc = bc;
    far.syn = op[`UCO_OPT_SYNC];
    far.pol = c0[`UCO_C0_CLK_POL];
    far.en = 1'b1;
    c = far.rx_count;
    wr(`UCO_TXDATA_OFF, 8'h1E);
    rxw(c);
    cmp(far.rx_count[7:0], 8'(c + 1));
    rd(`UCO_CTRL0_OFF, c0 | {4'h0, op[`UCO_OPT_SYNC], 3'h0});
    cmp(far.rx_byte, x);
    done(c0);
  endtask
  // word must wait while sending is blocked, then go out
  task automatic held(input logic [7:0] c0);
    int c;
    c = far.rx_count;
    wr(`UCO_CTRL0_OFF, c0);
    wr(`UCO_TXDATA_OFF, 8'h3C);
    repeat (400) @(posedge clk);
    cmp(far.rx_count[7:0], c[7:0]);
    far.cts_n <= 1'b0;
    wr(`UCO_CTRL0_OFF, 8'h10);
    rxw(c);
    cmp(far.rx_count[7:0], 8'(c + 1));
    cmp(far.rx_byte, 8'h3C);
    done(8'h10);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    summarize;
  end
  // ==========
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    port_data_i = 1'b0;
    port_dir_i = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`UCO_CTRL0_OFF, 8'h08);
    wr(`UCO_CTRL0_OFF, 8'h94);
    rd(`UCO_CTRL0_OFF, 8'h9C);
    apb(1'b0, 12'h398, 32'h0);
    flag(e, 1'b1);
    frame(8'h10, 8'hA2, 1'b0, 16, 8'hE1);
    frame(8'h10, 8'hA4, 1'b1, 16, 8'h1E);
    frame(8'h90, 8'hA0, 1'b0, 16, 8'h78);
    frame(8'h90, 8'h20, 1'b0, 16, 8'h9E);
    frame(8'h11, 8'hA0, 1'b0, 128, 8'h1E);
    frame(8'h12, 8'hA0, 1'b0, 512, 8'h1E);
    frame(8'h10, 8'h30, 1'b0, 16, 8'h1E);
    frame(8'hD0, 8'h30, 1'b0, 16, 8'h78);
    frame(8'h10, 8'hA0, 1'b0, 16, 8'h1E);
    far.cts_n <= 1'b1;
    held(8'h00);
    held(8'h13);
    far.jam <= 1'b1;
    wr(`UCO_OPT_OFF, 8'hA8);
    wr(`UCO_TXDATA_OFF, 8'hFF);
    done(8'h10);
    flag(collision_irq_o, 1'b1);
    far.jam <= 1'b0;
    wr(`UCO_STATUS_OFF, 8'h01);
    flag(collision_irq_o, 1'b0);
    wr(`UCO_ADDR_OFF, 8'h55);
    wr(`UCO_OPT_OFF, 8'hC1);
    far.send(8'h33);
    repeat (20) @(posedge clk);
    flag(rx_irq_o, 1'b0);
    far.send(8'h55);
    repeat (20) @(posedge clk);
    flag(rx_irq_o, 1'b1);
    rd(`UCO_RXDATA_OFF, 8'h55);
    port_data_i <= 1'b1;
    port_dir_i <= 1'b1;
    wr(`UCO_CTRL0_OFF, 8'h10);
    repeat (2) @(posedge clk);
    flag(hs_o, 1'b1);
    flag(hs_oe, 1'b1);
    wr(`UCO_CTRL0_OFF, 8'h04);
    repeat (2) @(posedge clk);
    flag(hs_oe, 1'b1);
    flag(hs_o, 1'b0);
    flag(txd_o, 1'b0);
    flag(sclk_o, 1'b1);
    summarize;
  end
endmodule
`default_nettype wire
